// file: rms_pkg.sv
// constants, states and register map of the mode and status controller
// assumes a 50 MHz clock and the plain register port of the top module
package rms_pkg;

	// ------------------------------------------------------------------
	// clock and times
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CFG_BLINK_MS = 1000;
	localparam int unsigned ESC_BLINK_MS = 500;
	localparam int unsigned FAULT_BLINK_MS = 250;
	localparam int unsigned REBOOT_DELAY_MS = 5000;
	localparam int unsigned WAKE_OK_MS = 30;
	localparam int unsigned CFG_BLINK_CYCLES = CFG_BLINK_MS * CYC_PER_MS;
	localparam int unsigned ESC_BLINK_CYCLES = ESC_BLINK_MS * CYC_PER_MS;
	localparam int unsigned FAULT_BLINK_CYCLES = FAULT_BLINK_MS * CYC_PER_MS;
	localparam int unsigned REBOOT_DELAY_CYCLES = REBOOT_DELAY_MS * CYC_PER_MS;
	localparam int unsigned WAKE_OK_CYCLES = WAKE_OK_MS * CYC_PER_MS;

	// ------------------------------------------------------------------
	// service serial settings and configured serial reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] SVC_BAUD = 32'h0000_9600;
	localparam logic [3:0] SVC_DATA_BITS = 4'h8;
	localparam logic [1:0] SVC_PARITY = 2'h0;
	localparam logic [1:0] SVC_STOP_BITS = 2'h1;
	localparam logic [31:0] CFG_BAUD_RST = 32'h0000_2580;
	localparam logic [3:0] CFG_DATA_BITS_RST = 4'h8;
	localparam logic [1:0] CFG_PARITY_RST = 2'h0;
	localparam logic [1:0] CFG_STOP_BITS_RST = 2'h1;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_FRAME = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_FAULT = 8'h10;
	localparam logic [7:0] ADDR_GUARD = 8'h14;
	localparam int CTRL_CMD_MODE = 0;
	localparam int CTRL_ESCAPE = 1;
	localparam int CTRL_CFG_TOOL = 2;
	localparam int CTRL_SLEEP = 3;
	localparam int CTRL_PSAVE = 4;
	localparam logic CMD_MODE_RST = 1'b1;

	// ------------------------------------------------------------------
	// states and indicator patterns
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_ON = 5'b00010,
		ST_SLEEP = 5'b00100,
		ST_PSAVE = 5'b01000,
		ST_SAFE = 5'b10000
	} rms_state_type;

	localparam logic [2:0] PAT_STEADY = 3'h0;
	localparam logic [2:0] PAT_TX = 3'h1;
	localparam logic [2:0] PAT_ESC = 3'h2;
	localparam logic [2:0] PAT_CFG = 3'h3;
	localparam logic [2:0] PAT_FAULT = 3'h4;

endpackage

// file: rms_ctrl.sv
// operating mode and status indicator controller of the radio module
// assumes all inputs synchronous to clk_i; frame, transmit and fault
// events come from the radio and firmware sides of the module
//
// Function
// (RULE_01) service low forces serial 38400 8N1
// (RULE_02) service keeps mode; release restores configured serial
// (RULE_03) service low forces text command set on
// (RULE_04) indicator high idle, low during received frame
// (RULE_05) light sleep holds indicator statically low
// (RULE_06) transmitting toggles indicator each transmission interval
// (RULE_07) configuration connection toggles indicator every second
// (RULE_08) escape-enabled commands toggle indicator every 500 ms
// (RULE_09) fault toggles every 250 ms, code readable
// (RULE_10) fault enters safe mode, reboots 5 s later
// (RULE_11) safe mode blocks all radio transmit and receive
// (RULE_12) enable high moves module to on state
// (RULE_13) enable low: off state, volatile settings reset
// (RULE_14) light sleep: radio off, serial logic powered
// (RULE_15) transmit-data change wakes module from sleep
// (RULE_16) after wake, send OK within 30 ms
// (RULE_17) stays on until next sleep command
// (RULE_18) power save: receiver duty cycle follows frame timing
// (RULE_19) host waits for OK before normal traffic
// (RULE_20) indicator priority: fault, config, command, transmit, receive
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rms_ctrl
	import rms_pkg::*;
#(
	parameter int unsigned CFG_BLINK_CYC = CFG_BLINK_CYCLES,
	parameter int unsigned ESC_BLINK_CYC = ESC_BLINK_CYCLES,
	parameter int unsigned FAULT_BLINK_CYC = FAULT_BLINK_CYCLES,
	parameter int unsigned REBOOT_CYC = REBOOT_DELAY_CYCLES,
	parameter int unsigned WAKE_OK_CYC = WAKE_OK_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// host pins
	input wire logic module_enable_input_i,
	input wire logic service_access_n_i,
	input wire logic serial_transmit_data_input_i,
	// radio and firmware events
	input wire logic rx_frame_i,
	input wire logic tx_active_i,
	input wire logic tx_interval_tick_i,
	input wire logic fault_detect_i,
	input wire logic [7:0] fault_code_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// indicator and mode outputs
	output logic status_indicator_o,
	output logic radio_enable_o,
	output logic tx_allow_o,
	output logic rx_allow_o,
	output logic text_command_set_enable_o,
	output logic reboot_o,
	output logic ok_send_o,
	output logic [4:0] mode_o,
	// primary serial port settings
	output logic [31:0] serial_baud_o,
	output logic [3:0] serial_data_bits_o,
	output logic [1:0] serial_parity_o,
	output logic [1:0] serial_stop_bits_o
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		rms_state_type st;
		logic cmd_mode;
		logic escape;
		logic cfg_tool;
		logic psave_en;
		logic [31:0] cfg_baud;
		logic [7:0] cfg_frame;
		logic [31:0] guard;
		logic fault_flag;
		logic [7:0] fault_code;
		logic [31:0] safe_cnt;
		logic ok_pend;
		logic [31:0] ok_cnt;
		logic ok_send;
		logic reboot;
		logic txd_prev;
		logic rx_prev;
		logic [31:0] ps_cnt;
		logic [31:0] ps_interval;
		logic [2:0] pat;
		logic [31:0] blink_cnt;
		logic led;
		logic cmd_en;
		logic [31:0] baud;
		logic [7:0] frame;
		logic [31:0] rdata;
	} rms_regs_type;

	rms_regs_type q;
	rms_regs_type n;
	logic tx_ok;
	logic ps_rx_on;
	logic rx_ok;
	logic rx_seen;

	// ------------------------------------------------------------------
	// radio gating
	// ------------------------------------------------------------------
	always_comb begin
		ps_rx_on = (q.ps_interval <= q.guard) || (q.ps_cnt >= q.ps_interval - q.guard); // RULE_18
		tx_ok = (q.st == ST_ON); // RULE_11 RULE_14
		rx_ok = (q.st == ST_ON) || ((q.st == ST_PSAVE) && (ps_rx_on || rx_frame_i)); // RULE_11
		rx_seen = rx_frame_i && rx_ok;
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [31:0] half;
		logic toggle;
		half = 32'h0000_0001;
		toggle = 1'b0;
		n = q;
		n.ok_send = 1'b0;
		n.reboot = 1'b0;
		n.txd_prev = serial_transmit_data_input_i;
		n.rx_prev = rx_seen;
		n.rdata = 32'h0000_0000;

		// register reads, data in the next cycle
		if (reg_read_i) begin
			unique case (reg_addr_i)
				ADDR_CTRL: n.rdata = {27'h0, q.psave_en, 1'b0, q.cfg_tool, q.escape, q.cmd_mode};
				ADDR_BAUD: n.rdata = q.cfg_baud;
				ADDR_FRAME: n.rdata = {24'h0, q.cfg_frame};
				ADDR_STATUS: n.rdata = {22'h0, q.fault_flag, q.led, q.cmd_en,
					~service_access_n_i, 1'b0, q.st};
				ADDR_FAULT: n.rdata = {24'h0, q.fault_code}; // RULE_09
				ADDR_GUARD: n.rdata = q.guard;
				default: n.rdata = 32'h0000_0000;
			endcase
		end

		// register writes
		if (reg_write_i) begin
			unique case (reg_addr_i)
				ADDR_CTRL: begin
					n.cmd_mode = reg_wdata_i[CTRL_CMD_MODE];
					n.escape = reg_wdata_i[CTRL_ESCAPE];
					n.cfg_tool = reg_wdata_i[CTRL_CFG_TOOL];
					n.psave_en = reg_wdata_i[CTRL_PSAVE];
				end
				ADDR_BAUD: n.cfg_baud = reg_wdata_i;
				ADDR_FRAME: n.cfg_frame = reg_wdata_i[7:0];
				ADDR_GUARD: n.guard = reg_wdata_i;
				default: n.guard = n.guard;
			endcase
		end

		// mode sequencing; service access never enters here
		unique case (q.st)
			ST_OFF: begin
				if (module_enable_input_i) begin
					n.st = ST_ON; // RULE_12
				end
			end
			ST_ON: begin
				if (reg_write_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_SLEEP]) begin
					n.st = ST_SLEEP; // RULE_17
				end else if (n.psave_en) begin
					n.st = ST_PSAVE;
				end
			end
			ST_SLEEP: begin
				if (serial_transmit_data_input_i != q.txd_prev) begin
					n.st = ST_ON; // RULE_15
					n.ok_pend = 1'b1;
					n.ok_cnt = 32'h0000_0000;
				end
			end
			ST_PSAVE: begin
				if (!n.psave_en) begin
					n.st = ST_ON;
				end
			end
			ST_SAFE: begin
				n.safe_cnt = q.safe_cnt + 32'h0000_0001;
				if (q.safe_cnt >= REBOOT_CYC - 1) begin
					n.st = ST_ON; // RULE_10
					n.reboot = 1'b1;
					n.safe_cnt = 32'h0000_0000;
				end
			end
		endcase

		// fault from on or power save mode only; ignored in sleep, off and safe
		if (fault_detect_i && (q.st == ST_ON || q.st == ST_PSAVE)) begin
			n.st = ST_SAFE; // RULE_10
			n.safe_cnt = 32'h0000_0000;
			n.fault_flag = 1'b1;
			n.fault_code = fault_code_i; // RULE_09
		end

		// OK answer after wake
		if (q.ok_pend) begin
			n.ok_cnt = q.ok_cnt + 32'h0000_0001;
			if (q.ok_cnt >= WAKE_OK_CYC - 1) begin
				n.ok_pend = 1'b0;
				n.ok_send = 1'b1; // RULE_16
			end
		end

		// power save frame timing
		if (q.st == ST_PSAVE) begin
			n.ps_cnt = q.ps_cnt + 32'h0000_0001;
			if (rx_seen && !q.rx_prev) begin
				n.ps_interval = q.ps_cnt; // RULE_18
				n.ps_cnt = 32'h0000_0000;
			end
		end else begin
			n.ps_cnt = 32'h0000_0000;
			n.ps_interval = 32'h0000_0000;
		end

		// indicator pattern select, highest first
		if (q.st == ST_SAFE) begin
			n.pat = PAT_FAULT; // RULE_20
		end else if (q.st == ST_SLEEP || q.st == ST_OFF) begin
			n.pat = PAT_STEADY;
		end else if (q.cfg_tool) begin
			n.pat = PAT_CFG;
		end else if (q.escape && !q.cmd_mode) begin
			n.pat = PAT_ESC;
		end else if (tx_active_i && tx_ok) begin
			n.pat = PAT_TX;
		end else begin
			n.pat = PAT_STEADY;
		end
		unique case (n.pat)
			PAT_FAULT: half = FAULT_BLINK_CYC; // RULE_09
			PAT_CFG: half = CFG_BLINK_CYC; // RULE_07
			PAT_ESC: half = ESC_BLINK_CYC; // RULE_08
			default: half = 32'h0000_0001;
		endcase
		if (n.pat != q.pat) begin
			n.blink_cnt = 32'h0000_0000;
		end else if (q.blink_cnt >= half - 1) begin
			n.blink_cnt = 32'h0000_0000;
			toggle = 1'b1;
		end else begin
			n.blink_cnt = q.blink_cnt + 32'h0000_0001;
		end
		unique case (n.pat)
			PAT_FAULT, PAT_CFG, PAT_ESC: n.led = toggle ? ~q.led : q.led;
			PAT_TX: n.led = tx_interval_tick_i ? ~q.led : q.led; // RULE_06
			default: begin
				if (n.st == ST_SLEEP || n.st == ST_OFF) begin
					n.led = 1'b0; // RULE_05
				end else begin
					n.led = ~rx_seen; // RULE_04
				end
			end
		endcase

		// serial settings and command set
		n.cmd_en = n.cmd_mode || n.escape || !service_access_n_i; // RULE_03
		if (!service_access_n_i) begin
			n.baud = SVC_BAUD; // RULE_01
			n.frame = {SVC_DATA_BITS, SVC_PARITY, SVC_STOP_BITS};
		end else begin
			n.baud = n.cfg_baud; // RULE_02
			n.frame = n.cfg_frame;
		end

		// enable low drops all volatile state
		if (!module_enable_input_i) begin
			n.st = ST_OFF; // RULE_13
			n.cmd_mode = CMD_MODE_RST;
			n.escape = 1'b0;
			n.cfg_tool = 1'b0;
			n.psave_en = 1'b0;
			n.guard = 32'h0000_0000;
			n.fault_flag = 1'b0;
			n.fault_code = 8'h00;
			n.safe_cnt = 32'h0000_0000;
			n.ok_pend = 1'b0;
			n.ok_cnt = 32'h0000_0000;
			n.ok_send = 1'b0;
			n.reboot = 1'b0;
			n.ps_cnt = 32'h0000_0000;
			n.ps_interval = 32'h0000_0000;
			n.pat = PAT_STEADY;
			n.blink_cnt = 32'h0000_0000;
			n.led = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.st <= ST_OFF;
			q.cmd_mode <= CMD_MODE_RST;
			q.cfg_baud <= CFG_BAUD_RST;
			q.cfg_frame <= {CFG_DATA_BITS_RST, CFG_PARITY_RST, CFG_STOP_BITS_RST};
			q.txd_prev <= 1'b1;
			q.cmd_en <= CMD_MODE_RST;
			q.baud <= CFG_BAUD_RST;
			q.frame <= {CFG_DATA_BITS_RST, CFG_PARITY_RST, CFG_STOP_BITS_RST};
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o = q.rdata;
	assign status_indicator_o = q.led;
	assign radio_enable_o = (q.st == ST_ON) || (q.st == ST_PSAVE); // RULE_14
	assign tx_allow_o = tx_ok;
	assign rx_allow_o = rx_ok;
	assign text_command_set_enable_o = q.cmd_en;
	assign reboot_o = q.reboot;
	assign ok_send_o = q.ok_send;
	assign mode_o = q.st;
	assign serial_baud_o = q.baud;
	assign serial_data_bits_o = q.frame[7:4];
	assign serial_parity_o = q.frame[3:2];
	assign serial_stop_bits_o = q.frame[1:0];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_svc_serial;
		@(posedge clk_i) disable iff (reset_i)
		!service_access_n_i |=> serial_baud_o == SVC_BAUD && serial_data_bits_o == SVC_DATA_BITS;
	endproperty
	a_svc_serial: assert property (p_svc_serial) else $error("service serial not forced"); // RULE_01
	property p_svc_keeps_mode;
		@(posedge clk_i) disable iff (reset_i)
		$fell(service_access_n_i) && module_enable_input_i && q.st == ST_ON && !fault_detect_i
			&& !reg_write_i |=> mode_o == ST_ON;
	endproperty
	a_svc_keeps_mode: assert property (p_svc_keeps_mode) else $error("service changed mode"); // RULE_02
	property p_svc_cmd;
		@(posedge clk_i) disable iff (reset_i)
		!service_access_n_i |=> text_command_set_enable_o;
	endproperty
	a_svc_cmd: assert property (p_svc_cmd) else $error("command set not forced on"); // RULE_03
	property p_sleep_led;
		@(posedge clk_i) disable iff (reset_i)
		mode_o == ST_SLEEP && $past(mode_o) == ST_SLEEP |-> !status_indicator_o;
	endproperty
	a_sleep_led: assert property (p_sleep_led) else $error("indicator high in sleep"); // RULE_05
	property p_fault_entry;
		@(posedge clk_i) disable iff (reset_i)
		fault_detect_i && module_enable_input_i && mode_o == ST_ON
			|=> mode_o == ST_SAFE && q.fault_code == $past(fault_code_i);
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault did not enter safe mode"); // RULE_10
	property p_safe_block;
		@(posedge clk_i) disable iff (reset_i)
		mode_o == ST_SAFE |-> !tx_allow_o && !rx_allow_o && !radio_enable_o;
	endproperty
	a_safe_block: assert property (p_safe_block) else $error("radio open in safe mode"); // RULE_11
	property p_off;
		@(posedge clk_i) disable iff (reset_i)
		!module_enable_input_i |=> mode_o == ST_OFF && q.fault_code == 8'h00 && !q.escape;
	endproperty
	a_off: assert property (p_off) else $error("enable low did not reset"); // RULE_13
	property p_wake;
		@(posedge clk_i) disable iff (reset_i)
		mode_o == ST_SLEEP && module_enable_input_i && serial_transmit_data_input_i != q.txd_prev
			|=> mode_o == ST_ON && q.ok_pend;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on transmit-data change"); // RULE_15
	property p_ok_after_wake;
		@(posedge clk_i) disable iff (reset_i)
		ok_send_o |-> $past(q.ok_pend) && !q.ok_pend;
	endproperty
	a_ok_after_wake: assert property (p_ok_after_wake) else $error("OK without wake"); // RULE_16
	property p_rx_led;
		@(posedge clk_i) disable iff (reset_i)
		module_enable_input_i && mode_o == ST_ON && !q.cfg_tool && !(q.escape && !q.cmd_mode)
			&& !tx_active_i && !fault_detect_i && !reg_write_i
			|=> status_indicator_o == !$past(rx_frame_i);
	endproperty
	a_rx_led: assert property (p_rx_led) else $error("receive indicator wrong"); // RULE_04 RULE_20

endmodule

// file: rms_host.sv
// host terminal model driving enable, service access and transmit data
// assumes the controller clock and its ok_send_o pulse
`timescale 1ns/1ps
module rms_host (
	// clock
	input wire logic clk_i,
	// from the module
	input wire logic ok_send_i,
	// host pins
	output logic enable_o,
	output logic service_n_o,
	output logic txd_o
);
	initial begin
		enable_o = 1'b0;
		service_n_o = 1'b1;
		txd_o = 1'b1;
	end
	task automatic power(input logic on);
		@(posedge clk_i);
		enable_o <= on;
	endtask
	task automatic service(input logic n);
		@(posedge clk_i);
		service_n_o <= n;
	endtask
	// low pulse on transmit data, no traffic until ok or timeout
	task automatic wake(input int pulse, output int ok_cyc);
		int n;
		n = 0;
		ok_cyc = -1;
		@(posedge clk_i);
		txd_o <= 1'b0;
		while (n < pulse || (ok_cyc < 0 && n < 4 * pulse)) begin
			@(posedge clk_i);
			n++;
			if (n == pulse) txd_o <= 1'b1;
			#1;
			if (ok_send_i === 1'b1 && ok_cyc < 0) ok_cyc = n;
		end
	endtask
endmodule

// file: tb.sv
// self-checking bench of the mode and status controller
// assumes shortened blink, reboot and wake counts
`timescale 1ns/1ps
module tb;
	import rms_pkg::*;
	localparam int CFG_H = 20;
	localparam int ESC_H = 10;
	localparam int FLT_H = 5;
	localparam int RBT = 50;
	localparam int WOK = 15;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic rx_frame = 1'b0;
	logic tx_act = 1'b0;
	logic tick = 1'b0;
	logic fault = 1'b0;
	logic [7:0] fcode = 8'h00;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic ind, radio_en, tx_ok, rx_ok, cmd_en, reboot, ok_send;
	logic [4:0] mode;
	logic [31:0] baud;
	logic [3:0] dbits;
	logic [1:0] par, stop;
	logic en, svc_n, txd;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	always #10 clk_i = ~clk_i;
	rms_host host (.clk_i(clk_i), .ok_send_i(ok_send), .enable_o(en), .service_n_o(svc_n),
		.txd_o(txd));
	rms_ctrl #(.CFG_BLINK_CYC(CFG_H), .ESC_BLINK_CYC(ESC_H), .FAULT_BLINK_CYC(FLT_H),
		.REBOOT_CYC(RBT), .WAKE_OK_CYC(WOK)) dut (
		.clk_i(clk_i), .reset_i(reset_i), .module_enable_input_i(en),
		.service_access_n_i(svc_n), .serial_transmit_data_input_i(txd),
		.rx_frame_i(rx_frame), .tx_active_i(tx_act), .tx_interval_tick_i(tick),
		.fault_detect_i(fault), .fault_code_i(fcode), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
		.status_indicator_o(ind), .radio_enable_o(radio_en), .tx_allow_o(tx_ok),
		.rx_allow_o(rx_ok), .text_command_set_enable_o(cmd_en), .reboot_o(reboot),
		.ok_send_o(ok_send), .mode_o(mode), .serial_baud_o(baud),
		.serial_data_bits_o(dbits), .serial_parity_o(par), .serial_stop_bits_o(stop));
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// cycles between two indicator toggles
	task automatic blink(input int exp, input string what);
		logic last;
		int n;
		settle(1);
		for (int k = 0; k < 2; k++) begin
			last = ind;
			n = 0;
			while (ind === last && n < 200) begin
				settle(1);
				n++;
			end
		end
		chk(n, exp, what);
	endtask
	function automatic logic [63:0] ser_exp(logic [31:0] b, logic [7:0] f);
		return {24'h0, b, f[7:4], f[3:2], f[1:0]};
	endfunction
	// indicator half period from control bits, 0 means steady
	function automatic int half_exp(logic [2:0] c);
		if (c[2]) return CFG_H;
		if (c[1] && !c[0]) return ESC_H;
		return 0;
	endfunction
	initial begin
		logic [31:0] r, cb;
		logic [7:0] code;
		int okc, len;
		time t0;
		void'($urandom(32'h5D8F416B));
		host.power(1'b1);
		settle(1);
		@(posedge clk_i);
		reset_i <= 1'b0;
		settle(3);
		chk(mode, ST_ON, "on after enable");
		chk({baud, dbits, par, stop}, ser_exp(CFG_BAUD_RST, {CFG_DATA_BITS_RST, CFG_PARITY_RST,
			CFG_STOP_BITS_RST}), "reset serial");
		cb = 32'h1000 + $urandom % 32'h10000;
		reg_wr(ADDR_BAUD, cb);
		reg_wr(ADDR_FRAME, 32'h85);
		reg_wr(ADDR_CTRL, 32'h0);
		host.service(1'b0);
		settle(3);
		chk({baud, dbits, par, stop}, ser_exp(SVC_BAUD, 8'h80 | 8'h01), "svc serial");
		chk(cmd_en, 1'b1, "svc cmd");
		chk(mode, ST_ON, "svc mode");
		reg_rd(ADDR_STATUS, r);
		chk(r, {22'h0, 5'b01110, ST_ON}, "svc status");
		host.service(1'b1);
		settle(3);
		chk({baud, dbits, par, stop}, ser_exp(cb, 8'h85), "cfg serial");
		len = 3 + $urandom % 8;
		@(posedge clk_i);
		rx_frame <= 1'b1;
		settle(2);
		for (int i = 0; i < len; i++) begin
			chk(ind, 1'b0, "frame low");
			settle(1);
		end
		@(posedge clk_i);
		rx_frame <= 1'b0;
		settle(2);
		chk(ind, 1'b1, "idle high");
		for (int c = 0; c < 8; c++) begin
			reg_wr(ADDR_CTRL, c);
			settle(3);
			chk(cmd_en, c[0] | c[1], "cmd enable");
			if (half_exp(c[2:0]) > 0) blink(half_exp(c[2:0]), "blink");
			else chk(ind, 1'b1, "steady");
		end
		reg_wr(ADDR_CTRL, 32'h1);
		tx_act <= 1'b1;
		fork
			repeat (6) begin
				repeat (6) @(posedge clk_i);
				tick <= 1'b1;
				@(posedge clk_i);
				tick <= 1'b0;
			end
			blink(7, "tx blink");
		join
		tx_act <= 1'b0;
		code = 8'($urandom);
		@(posedge clk_i);
		fault <= 1'b1;
		fcode <= code;
		rx_frame <= 1'b1;
		@(posedge clk_i);
		fault <= 1'b0;
		t0 = $time;
		settle(1);
		chk({mode, tx_ok, rx_ok}, {ST_SAFE, 2'b00}, "safe blocks radio");
		blink(FLT_H, "fault blink");
		reg_rd(ADDR_FAULT, r);
		chk(r, {24'h0, code}, "fault code");
		while (mode !== ST_ON && ($time - t0) < 2000) settle(1);
		len = ($time - t0) / 20;
		chk(len >= RBT - 1 && len <= RBT + 2, 1'b1, "reboot delay");
		chk(reboot, 1'b1, "reboot pulse");
		@(posedge clk_i);
		rx_frame <= 1'b0;
		reg_wr(ADDR_CTRL, 32'h9);
		settle(3);
		chk({mode, ind, radio_en}, {ST_SLEEP, 2'b00}, "sleep");
		fork
			host.wake(500, okc);
			begin
				settle(3);
				chk(mode, ST_ON, "woken");
			end
		join
		chk(okc >= 2 && okc <= WOK + 3, 1'b1, "ok reply");
		settle(100);
		chk(mode, ST_ON, "stays on");
		reg_wr(ADDR_GUARD, 32'h4);
		reg_wr(ADDR_CTRL, 32'h11);
		settle(3);
		chk({mode, radio_en}, {ST_PSAVE, 1'b1}, "psave");
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_i);
			rx_frame <= 1'b1;
			settle(2);
			@(posedge clk_i);
			rx_frame <= 1'b0;
			settle(k < 4 ? 36 : 17);
		end
		chk(rx_ok, 1'b0, "rx window shut");
		settle(18);
		chk(rx_ok, 1'b1, "rx window open");
		host.power(1'b0);
		settle(3);
		chk({mode, ind}, {ST_OFF, 1'b0}, "off");
		host.power(1'b1);
		settle(3);
		chk(mode, ST_ON, "on again");
		reg_rd(ADDR_CTRL, r);
		chk(r, 32'h1, "ctrl reset");
		reg_rd(ADDR_FAULT, r);
		chk(r, 32'h0, "fault cleared");
		reg_rd(8'hF0, r);
		chk(r, 32'h0, "unmapped");
		report_and_stop();
	end
endmodule
